/* File: hw/fcs_buscycle.sv */
// Single flash bus cycle engine: one write or one read on the pins.
// Assumes the caller holds the request stable until done pulses.
module fcs_buscycle
   import fcs_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic                  start,
   input  wire logic                  is_write,
   input  wire logic [FCS_ADDR_W-1:0] addr,
   input  wire logic [7:0]            wdata,
   input  wire logic [7:0]            dq_in,
   output logic                       done,
   output logic [7:0]                 rdata_ff,
   output logic                       ce_n_ff,
   output logic                       oe_n_ff,
   output logic                       we_n_ff,
   output logic [FCS_ADDR_W-1:0]      a_ff,
   output logic [7:0]                 dq_out_ff,
   output logic                       dq_oe_ff
);
   logic [2:0] ph_ff;
   logic [2:0] cnt_ff;
   logic [7:0] dq_s1_ff, dq_s2_ff, dq_s3_ff;
   // Phase 0 idle, 1 setup, 2 strobe low, 3 strobe high hold
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ph_ff  <= 3'h0;
         cnt_ff <= 3'h0;
      end else if (ph_ff == 3'h0) begin
         if (start) begin
            ph_ff  <= 3'h1;
            cnt_ff <= 3'(FCS_STROBE_CYC - 1);
         end
      end else if (cnt_ff != 3'h0) begin
         cnt_ff <= cnt_ff - 3'h1;
      end else begin
         ph_ff  <= (ph_ff == 3'h3) ? 3'h0 : ph_ff + 3'h1;
         cnt_ff <= 3'(FCS_STROBE_CYC - 1);
      end
   end
   assign done = (ph_ff == 3'h3) && (cnt_ff == 3'h0);
   // Pin drive; writes keep gate high so select and strobe alone act
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ce_n_ff   <= 1'b1;
         oe_n_ff   <= 1'b1;
         we_n_ff   <= 1'b1;
         a_ff      <= '0;
         dq_out_ff <= 8'h00;
         dq_oe_ff  <= 1'b0;
      end else begin
         ce_n_ff   <= !((ph_ff == 3'h1) || (ph_ff == 3'h2) || (start && ph_ff == 3'h0)) ||
                      (done);
         oe_n_ff   <= !(!is_write && ph_ff == 3'h2 && !(cnt_ff == 3'h0 && 1'b0));
         we_n_ff   <= !(is_write && ph_ff == 3'h1 && cnt_ff == 3'h0) &&
                      !(is_write && ph_ff == 3'h2 && cnt_ff != 3'h0);
         if (start && ph_ff == 3'h0)
            a_ff <= addr;                    // Stable before strobe falls
         dq_out_ff <= wdata;                 // Stable through strobe rise
         dq_oe_ff  <= is_write && (ph_ff != 3'h0 || start) && !done;
      end
   end
   // Three-stage pin sampling; accept when stages two and three agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dq_s1_ff <= 8'h00;
         dq_s2_ff <= 8'h00;
         dq_s3_ff <= 8'h00;
         rdata_ff <= 8'h00;
      end else begin
         dq_s1_ff <= dq_in;
         dq_s2_ff <= dq_s1_ff;
         dq_s3_ff <= dq_s2_ff;
         if (!is_write && ph_ff == 3'h3 && dq_s2_ff == dq_s3_ff)
            rdata_ff <= dq_s3_ff;
      end
   end
endmodule // fcs_buscycle

/* File: hw/fcs_host.sv */
// Host controller that runs flash command sequences on the device pins.
// Assumes an APB master on clk; the device is asynchronous and clockless.
//
// Decided for this implementation: the APB slave port and the register offsets.
module fcs_host
   import fcs_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic                       ce_n,
   output logic                       oe_n,
   output logic                       we_n,
   output logic [FCS_ADDR_W-1:0]      addr,
   output logic [7:0]                 dq_out,
   output logic                       dq_oe,
   input  wire logic [7:0]            dq_in,
   output logic                       vpp_high,
   output logic                       id_high_voltage
);
   fcs_state_t st_ff;
   fcs_op_t    op_ff;
   logic [FCS_ADDR_W-1:0] addr_reg_ff;
   logic [7:0]  wdata_reg_ff, rdata_reg_ff, last_ff;
   logic        busy_ff, fail_ff, tmo_ff, seq_ff, par_ff, tog_ff;
   logic [10:0] wait_ff;
   logic        bc_start, bc_write, bc_done;
   logic [FCS_ADDR_W-1:0] bc_addr;
   logic [7:0]  bc_wdata, bc_rdata;
   logic [31:0] nxt_prdata;
   logic        wr_go;

   // Odd parity check of an id byte
   function automatic logic odd_par(input logic [7:0] b);
      return ^b;
   endfunction
   // Address decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   assign wr_go = psel && penable && pwrite && hit(paddr, FCS_OFF_CMD) &&
                  pwdata[FCS_CMD_GO_BIT] && !busy_ff;

   // Software registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addr_reg_ff  <= '0;
         wdata_reg_ff <= 8'h00;
         op_ff        <= FCS_OP_READ;
      end else if (psel && penable && pwrite) begin
         if (hit(paddr, FCS_OFF_ADDR))
            addr_reg_ff <= pwdata[FCS_ADDR_W-1:0];
         if (hit(paddr, FCS_OFF_WDATA))
            wdata_reg_ff <= pwdata[7:0];
         if (wr_go)
            op_ff <= fcs_op_t'(pwdata[FCS_CMD_OP_LSB +: 3]);
      end
   end

   // APB read mux, one-wait-free answer
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      if (hit(paddr, FCS_OFF_CMD))
         nxt_prdata = {28'h0000000, 1'b0, op_ff};
      else if (hit(paddr, FCS_OFF_ADDR))
         nxt_prdata = {{(32-FCS_ADDR_W){1'b0}}, addr_reg_ff};
      else if (hit(paddr, FCS_OFF_WDATA))
         nxt_prdata = {24'h000000, wdata_reg_ff};
      else if (hit(paddr, FCS_OFF_STATUS))
         nxt_prdata = {27'h0000000, par_ff, seq_ff, tmo_ff, fail_ff, busy_ff};
      else if (hit(paddr, FCS_OFF_RDATA))
         nxt_prdata = {24'h000000, rdata_reg_ff};
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= nxt_prdata;
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !(hit(paddr, FCS_OFF_CMD) ||
                    hit(paddr, FCS_OFF_ADDR) || hit(paddr, FCS_OFF_WDATA) ||
                    hit(paddr, FCS_OFF_STATUS) || hit(paddr, FCS_OFF_RDATA));
      end
   end

   // Bus cycle request for current state
   always_comb begin
      bc_start = 1'b0;
      bc_write = 1'b0;
      bc_addr  = addr_reg_ff;
      bc_wdata = FCS_CODE_READ;
      case (st_ff)
         FCS_S_W1: begin
            bc_start = 1'b1;
            bc_write = 1'b1;
            case (op_ff)
               FCS_OP_ERASE:   bc_wdata = FCS_CODE_ERASE;
               FCS_OP_PROGRAM: bc_wdata = FCS_CODE_PROG;
               FCS_OP_RESET:   bc_wdata = FCS_CODE_RESET;
               FCS_OP_ID_CMD:  bc_wdata = FCS_CODE_AUTOSEL;
               default:        bc_wdata = FCS_CODE_READ;
            endcase
         end
         FCS_S_W2: begin
            bc_start = 1'b1;
            bc_write = 1'b1;
            case (op_ff)
               FCS_OP_ERASE:   bc_wdata = FCS_CODE_ERASE;
               FCS_OP_RESET:   bc_wdata = FCS_CODE_RESET;
               default:        bc_wdata = wdata_reg_ff;
            endcase
         end
         FCS_S_RD, FCS_S_POLL: bc_start = 1'b1;
         default: bc_start = 1'b0;
      endcase
   end

   // Sequencer; only known codes ever issued
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_ff   <= FCS_S_IDLE;
         wait_ff <= 11'h000;
      end else begin
         case (st_ff)
            FCS_S_IDLE: if (wr_go) begin
               case (fcs_op_t'(pwdata[FCS_CMD_OP_LSB +: 3]))
                  FCS_OP_READ, FCS_OP_ID_HV: st_ff <= FCS_S_RD;
                  default: st_ff <= FCS_S_W1;
               endcase
            end
            FCS_S_W1: if (bc_done) begin
               case (op_ff)
                  FCS_OP_ERASE, FCS_OP_PROGRAM, FCS_OP_RESET: st_ff <= FCS_S_W2;
                  FCS_OP_ID_CMD: st_ff <= FCS_S_RD;  // Id read in autoselect mode
                  FCS_OP_READCMD: begin
                     wait_ff <= 11'(FCS_READ_WAIT_CYC);
                     st_ff   <= FCS_S_WAIT;
                  end
                  default: st_ff <= FCS_S_DONE;
               endcase
            end
            FCS_S_W2: if (bc_done)
               st_ff <= (op_ff == FCS_OP_RESET) ? FCS_S_DONE : FCS_S_POLL;
            FCS_S_WAIT: begin
               if (wait_ff == 11'h000)
                  st_ff <= FCS_S_RD;  // First array read only after delay
               else
                  wait_ff <= wait_ff - 11'h001;
            end
            FCS_S_RD: if (bc_done) st_ff <= FCS_S_DONE;
            FCS_S_POLL: if (bc_done) st_ff <= FCS_S_CHECK;
            FCS_S_CHECK: begin
               // Poll again unless bit 7 settled or device timed out
               if (bc_rdata[FCS_POLL_BIT] == ((op_ff == FCS_OP_ERASE) ? 1'b1 :
                   wdata_reg_ff[FCS_POLL_BIT]))
                  st_ff <= (op_ff == FCS_OP_ERASE) ? FCS_S_RD : FCS_S_DONE;
               else if (bc_rdata[FCS_TMO_BIT])
                  st_ff <= FCS_S_DONE;  // Stop so software can reset
               else
                  st_ff <= FCS_S_POLL;
            end
            FCS_S_DONE: st_ff <= FCS_S_IDLE;
            default: st_ff <= FCS_S_IDLE;
         endcase
      end
   end

   // Status capture
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_ff      <= 1'b0;
         fail_ff      <= 1'b0;
         tmo_ff       <= 1'b0;
         seq_ff       <= 1'b0;
         par_ff       <= 1'b0;
         rdata_reg_ff <= 8'h00;
         last_ff      <= 8'h00;
         tog_ff       <= 1'b0;
      end else begin
         if (wr_go) begin
            busy_ff <= 1'b1;
            fail_ff <= 1'b0;
            tmo_ff  <= 1'b0;
         end else if (st_ff == FCS_S_DONE)
            busy_ff <= 1'b0;
         if (st_ff == FCS_S_CHECK && bc_rdata[FCS_TMO_BIT] &&
             bc_rdata[FCS_POLL_BIT] != ((op_ff == FCS_OP_ERASE) ? 1'b1 :
             wdata_reg_ff[FCS_POLL_BIT])) begin
            tmo_ff <= 1'b1;
            seq_ff <= bc_rdata[4];
         end
         if (st_ff == FCS_S_RD && bc_done) begin
            rdata_reg_ff <= bc_rdata;
            par_ff       <= odd_par(bc_rdata);
            if (op_ff == FCS_OP_ERASE && bc_rdata != FCS_ERASED)
               fail_ff <= 1'b1;
         end
         if (st_ff == FCS_S_CHECK) begin
            last_ff <= bc_rdata;
            tog_ff  <= bc_rdata[6] ^ last_ff[6];
         end
      end
   end

   // Supply and id pins; high id voltage only with low program supply
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         vpp_high        <= 1'b0;
         id_high_voltage <= 1'b0;
      end else begin
         vpp_high        <= busy_ff && op_ff != FCS_OP_ID_HV && op_ff != FCS_OP_READ;
         id_high_voltage <= busy_ff && op_ff == FCS_OP_ID_HV;
      end
   end

   fcs_buscycle u_bc (
      .clk       (clk),
      .nrst      (nrst),
      .start     (bc_start),
      .is_write  (bc_write),
      .addr      (bc_addr),
      .wdata     (bc_wdata),
      .dq_in     (dq_in),
      .done      (bc_done),
      .rdata_ff  (bc_rdata),
      .ce_n_ff   (ce_n),
      .oe_n_ff   (oe_n),
      .we_n_ff   (we_n),
      .a_ff      (addr),
      .dq_out_ff (dq_out),
      .dq_oe_ff  (dq_oe)
   );
   // Command latch sits at no array address; kept by issuing only strobe cycles
endmodule // fcs_host

/* File: hw/fcs_pkg.sv */
// Constants and types shared by the flash command host controller.
// Assumes a 200 MHz clk and a byte-wide flash device driven through its pins.
// Contract
// - High voltage id: A0 selects maker/device byte
// - Write needs select and strobe low, gate high
// - Upper three bits command, low five zero; codes 8'h30, 8'h50, 8'h90 and 8'hFF used here set low bits
// - Wait six microseconds after read command
// - Reset is two all-ones writes
// - Erase is two erase-code writes
// - Host checks erased byte reads all ones
// - Program: set-up code, then address and data
// - Autoselect code maps address 0/1 to ids
package fcs_pkg;
   // Register offsets of the controller
   localparam logic [7:0] FCS_OFF_CMD    = 8'h00;
   localparam logic [7:0] FCS_OFF_ADDR   = 8'h04;
   localparam logic [7:0] FCS_OFF_WDATA  = 8'h08;
   localparam logic [7:0] FCS_OFF_STATUS = 8'h0C;
   localparam logic [7:0] FCS_OFF_RDATA  = 8'h10;
   // Command register fields
   localparam int FCS_CMD_OP_LSB  = 0;
   localparam int FCS_CMD_GO_BIT  = 4;
   // Status fields
   localparam int FCS_ST_BUSY     = 0;
   localparam int FCS_ST_FAIL     = 1;
   localparam int FCS_ST_TMO      = 2;
   localparam int FCS_ST_SEQ      = 3;
   localparam int FCS_ST_PARITY   = 4;
   // Device command codes
   localparam logic [7:0] FCS_CODE_READ   = 8'h00;
   localparam logic [7:0] FCS_CODE_ERASE  = 8'h30;
   localparam logic [7:0] FCS_CODE_PROG   = 8'h50;
   localparam logic [7:0] FCS_CODE_AUTOSEL = 8'h90;
   localparam logic [7:0] FCS_CODE_RESET  = 8'hFF;
   localparam logic [7:0] FCS_ERASED      = 8'hFF;
   // Device data bit positions
   localparam int FCS_POLL_BIT    = 7;
   localparam int FCS_TMO_BIT     = 5;
   // Timing
   localparam int FCS_CLK_MHZ     = 200;
   localparam int FCS_READ_WAIT_US = 6;
   localparam int FCS_READ_WAIT_CYC = FCS_READ_WAIT_US * FCS_CLK_MHZ;
   localparam int FCS_STROBE_CYC  = 4;  // Phase length of a bus cycle
   localparam int FCS_ADDR_W      = 18;
   // Host operations requested by software
   typedef enum logic [2:0] {
      FCS_OP_READ    = 3'h0,
      FCS_OP_ID_HV   = 3'h1,
      FCS_OP_ID_CMD  = 3'h2,
      FCS_OP_PROGRAM = 3'h3,
      FCS_OP_ERASE   = 3'h4,
      FCS_OP_RESET   = 3'h5,
      FCS_OP_READCMD = 3'h6
   } fcs_op_t;
   // Bus cycle sequencer states, Gray along the usual path
   typedef enum logic [3:0] {
      FCS_S_IDLE  = 4'h0,
      FCS_S_W1    = 4'h1,
      FCS_S_W2    = 4'h3,
      FCS_S_WAIT  = 4'h2,
      FCS_S_RD    = 4'h6,
      FCS_S_POLL  = 4'h7,
      FCS_S_CHECK = 4'h5,
      FCS_S_DONE  = 4'h4
   } fcs_state_t;
endpackage

/* File: tb/fcs_flash_model.sv */
// Behavioural byte-wide flash device with command latch and self-timed ops.
// Assumes host strobes as pins; only the low 8 address bits select a byte.
module fcs_flash_model #(
   parameter logic [7:0] MAKER_CODE  = 8'h15, // Arbitrary value, odd parity
   parameter logic [7:0] DEVICE_CODE = 8'h8C, // Arbitrary value, odd parity
   parameter int         PROG_NS     = 2000,
   parameter int         ERASE_NS    = 20000,
   parameter logic [7:0] STUCK_ADDR  = 8'hEE  // Byte whose program runs out of time
) (
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [17:0] addr,
   input  wire logic [7:0]  dq_out,
   input  wire logic        dq_oe,
   input  wire logic        vpp_high,
   input  wire logic        id_high_voltage,
   output logic [7:0]       dq_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [0:255];
   logic [7:0]  cmd_ff = 8'h00;
   logic [7:0]  pval = 8'h00;
   logic [7:0]  v;
   logic [7:0]  last_rd = 8'h00;
   logic [17:0] wa;
   logic        busy = 1'b0;
   logic        erasing = 1'b0;
   logic        tgl = 1'b0;
   logic        id_mode = 1'b0;
   logic        tmo = 1'b0;
   wire         wr_ok = !ce_n && oe_n && vpp_high && dq_oe;
   // Array starts erased
   initial foreach (mem[i]) mem[i] = 8'hFF;
   // Address taken on strobe fall
   always @(negedge we_n) if (wr_ok) wa = addr;
   // Data taken on strobe rise; latch never maps onto the array
   always @(posedge we_n) if (wr_ok && (!busy || tmo)) begin
      if (tmo) begin
         // Only a full reset pair leaves the timed-out state
         if (cmd_ff == 8'hFF && dq_out == 8'hFF) begin
            busy = 1'b0;
            tmo = 1'b0;
            cmd_ff = 8'h00;
         end else
            cmd_ff = dq_out;
      end else if (cmd_ff == 8'h50) begin
         pval = dq_out;
         busy = 1'b1;
         #(PROG_NS);
         if (wa[7:0] == STUCK_ADDR) begin
            tmo = 1'b1;
         end else begin
            mem[wa[7:0]] = pval;
            busy = 1'b0;
            cmd_ff = 8'h00;
         end
      end else if (cmd_ff == 8'h30 && dq_out == 8'h30) begin
         erasing = 1'b1;
         busy = 1'b1;
         foreach (mem[i]) mem[i] = 8'h00;
         #(ERASE_NS) foreach (mem[i]) mem[i] = 8'hFF;
         busy = 1'b0;
         erasing = 1'b0;
         cmd_ff = 8'h00;
      end else if (cmd_ff == 8'hFF && dq_out == 8'hFF) begin
         cmd_ff = 8'h00;
         id_mode = 1'b0;
      end else if (dq_out inside {8'h00, 8'h30, 8'h50, 8'hFF}) begin
         cmd_ff = dq_out;
         id_mode = 1'b0;
      end else if (dq_out inside {8'h80, 8'h90}) begin
         cmd_ff = dq_out;
         id_mode = 1'b1;
      end // Other codes leave the mode alone
   end
   // Supply drop forces read mode
   always @(negedge vpp_high) begin
      cmd_ff = 8'h00;
      id_mode = 1'b0;
   end
   // Toggle flips on each read while busy
   always @(negedge oe_n) if (busy) tgl = ~tgl;
   // Read value
   always_comb begin
      if (id_high_voltage && !vpp_high) v = addr[0] ? DEVICE_CODE : MAKER_CODE;
      else if (busy) v = {erasing ? 1'b0 : ~pval[7], tgl, tmo, erasing, 4'h0};
      else if (id_mode) v = addr[0] ? DEVICE_CODE : MAKER_CODE;
      else v = mem[addr[7:0]];
   end
   // Released bus shows the inverse of the last byte
   always @(posedge oe_n) last_rd = v;
   assign dq_in = (!ce_n && !oe_n) ? v : ~last_rd;
endmodule // fcs_flash_model

/* File: tb/fcs_host_monitor.sv */
// Concurrent checks on the flash host controller's APB side and flash pins.
// Assumes one clk domain with async active-low nrst; bound onto fcs_host.
module fcs_host_monitor
   import fcs_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  nrst,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic                  ce_n,
   input wire logic                  oe_n,
   input wire logic                  we_n,
   input wire logic [FCS_ADDR_W-1:0] addr,
   input wire logic [7:0]            dq_out,
   input wire logic                  dq_oe,
   input wire logic                  vpp_high,
   input wire logic                  id_high_voltage
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Bus steps
   sequence s_setup; psel && !penable; endsequence
   sequence s_we_low; !we_n [*4]; endsequence
   property p_answer; s_setup |=> pready && psel && penable; endproperty
   property p_ready_pulse; pready |=> !pready; endproperty
   property p_err_ready; pslverr |-> pready && psel && penable; endproperty
   property p_we_len; $fell(we_n) |-> s_we_low; endproperty
   property p_write_qual; !we_n |-> !ce_n && oe_n && dq_oe; endproperty
   property p_write_vpp; !we_n |-> vpp_high && !id_high_voltage; endproperty
   property p_hold; !we_n && !$past(we_n) |-> $stable(addr) && $stable(dq_out); endproperty
   property p_no_contend; !oe_n |-> !dq_oe; endproperty
   property p_id_low_vpp; id_high_voltage |-> !vpp_high && we_n; endproperty
   a_answer: assert property (p_answer) else $error("no zero-wait answer");
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   a_err_ready: assert property (p_err_ready) else $error("pslverr outside access");
   a_we_len: assert property (p_we_len) else $error("write strobe too short");
   a_write_qual: assert property (p_write_qual) else $error("write with bad strobes");
   a_write_vpp: assert property (p_write_vpp) else $error("write without supply");
   a_hold: assert property (p_hold) else $error("address or data moved");
   a_no_contend: assert property (p_no_contend) else $error("drive during read");
   a_id_low_vpp: assert property (p_id_low_vpp) else $error("id voltage with supply");
endmodule // fcs_host_monitor

bind fcs_host fcs_host_monitor u_fcs_host_monitor (.clk(clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .ce_n(ce_n), .oe_n(oe_n),
   .we_n(we_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .vpp_high(vpp_high),
   .id_high_voltage(id_high_voltage));

/* File: tb/test_flash_command_sequencer.sv */
// Self-checking bench: APB tasks drive host ops against the flash model.
// Assumes zero-wait APB answers and a go bit that starts one flash op.
module test_flash_command_sequencer
   import fcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MAKER  = 8'h15; // Arbitrary identity value
   localparam logic [7:0] DEVICE = 8'h8C; // Arbitrary identity value
   logic                  clk, nrst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]            paddr, dq_out, dq_in;
   logic [31:0]           pwdata, prdata, rd, st;
   logic                  ce_n, oe_n, we_n, dq_oe, vpp_high, id_high_voltage;
   logic [FCS_ADDR_W-1:0] addr;
   int                    error_cnt = 0;
   int                    n_compared = 0;
   fcs_host u_fcs_host (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
      .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .vpp_high(vpp_high),
      .id_high_voltage(id_high_voltage));
   fcs_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) u_fcs_flash_model (
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_out(dq_out),
      .dq_oe(dq_oe), .vpp_high(vpp_high), .id_high_voltage(id_high_voltage), .dq_in(dq_in));
   // Clock at 200 MHz
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic end_sim;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer: setup, access until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Load address and data, start an op, poll busy, fetch read byte
   task automatic run(input fcs_op_t op, input logic [17:0] a, input logic [7:0] d);
      apb(1'b1, FCS_OFF_ADDR, {14'h0, a});
      apb(1'b1, FCS_OFF_WDATA, {24'h0, d});
      apb(1'b1, FCS_OFF_CMD, {27'h0, 1'b1, 1'b0, op});
      st = 32'h1;
      for (int i = 0; i < 20000 && st[FCS_ST_BUSY] !== 1'b0; i++) begin
         apb(1'b0, FCS_OFF_STATUS, 32'h0);
         st = rd;
      end
      check("op finished", 32'h0, {31'h0, st[FCS_ST_BUSY]});
      apb(1'b0, FCS_OFF_RDATA, 32'h0);
   endtask
   // Watchdog
   initial begin
      #300000;
      error_cnt++;
      $display("CHECK FAILED watchdog expected done seen hang");
      end_sim();
   end
   // Main sequence
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      apb(1'b0, FCS_OFF_STATUS, 32'h0);
      check("status after reset", 32'h0, rd);
      run(FCS_OP_ID_HV, 18'h0, 8'h00);
      check("maker by high voltage", {24'h0, MAKER}, rd);
      check("maker parity", 32'h1, {31'h0, st[FCS_ST_PARITY]});
      run(FCS_OP_ID_HV, 18'h1, 8'h00);
      check("device by high voltage", {24'h0, DEVICE}, rd);
      check("device parity", 32'h1, {31'h0, st[FCS_ST_PARITY]});
      run(FCS_OP_ID_CMD, 18'h0, 8'h00);
      check("maker by command", {24'h0, MAKER}, rd);
      run(FCS_OP_ID_CMD, 18'h1, 8'h00);
      check("device by command", {24'h0, DEVICE}, rd);
      run(FCS_OP_PROGRAM, 18'h5, 8'h3C);
      check("program status", 32'h0, {29'h0, st[2:0]});
      run(FCS_OP_READ, 18'h5, 8'h00);
      check("program readback", 32'h3C, rd);
      run(FCS_OP_PROGRAM, 18'h6, 8'hC3);
      check("program high bit status", 32'h0, {29'h0, st[2:0]});
      run(FCS_OP_READCMD, 18'h6, 8'h00);
      check("read command data", 32'hC3, rd);
      run(FCS_OP_ERASE, 18'h0, 8'h00);
      check("erase status", 32'h0, {29'h0, st[2:0]});
      run(FCS_OP_READ, 18'h5, 8'h00);
      check("erased byte", 32'hFF, rd);
      run(FCS_OP_PROGRAM, 18'hEE, 8'h5A);
      check("program timeout status", 32'h4, {28'h0, st[3:0]});
      run(FCS_OP_RESET, 18'h0, 8'h00);
      check("reset status", 32'h0, {31'h0, st[FCS_ST_BUSY]});
      check("reset clears timeout", 32'h0, {31'h0, st[FCS_ST_TMO]});
      run(FCS_OP_READ, 18'h6, 8'h00);
      check("read after reset", 32'hFF, rd);
      apb(1'b1, 8'h20, 32'h5A);
      check("unmapped write error", 32'h1, {31'h0, err});
      apb(1'b0, 8'h14, 32'h0);
      check("unmapped read error", 32'h1, {31'h0, err});
      end_sim();
   end
endmodule // test_flash_command_sequencer
